//--- inc/fsp_map.svh
// Purpose: named constants of the flash protect and hold block
// Assumes: included by bare name after the package
// Notes: command codes and timing default are local choices
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
// command codes
`define FSP_CMD_WR_ENABLE 8'h06
`define FSP_CMD_WR_DISABLE 8'h04
`define FSP_CMD_STAT_READ 8'h05
`define FSP_CMD_STAT_WRITE 8'h01
`define FSP_CMD_PAGE_PROG 8'h02
`define FSP_CMD_SECT_ERASE 8'hd8
`define FSP_CMD_BULK_ERASE 8'hc7
// status byte layout
`define FSP_ST_BUSY 0
`define FSP_ST_LATCH 1
`define FSP_ST_GUARD_LO 2
`define FSP_ST_GUARD_HI 5
`define FSP_ST_LOCK 7
// serial clock counts
`define FSP_BYTE_LAST 3'h7
`define FSP_BYTE_WHOLE 3'h0
`define FSP_CNT_OPCODE 12'h008
`define FSP_CNT_SRDATA 12'h010
`define FSP_CNT_ADDR 12'h020
`define FSP_CNT_PROG 12'h028
// protect region decode: address in 128 KB units
`define FSP_UNIT_HI 23
`define FSP_UNIT_LO 17
`define FSP_UNITS_ALL 8'h80
// pins {wpN, holdN, si, csN, sck} and their idle level
`define FSP_PIN_W 5
`define FSP_PIN_IDLE 5'h1a
// status write duration in clk_sys cycles
`define FSP_SR_WRITE_DEF 16'h03e8
`endif

//--- inc/fsp_pkg.sv
// Purpose: types of the flash protect and hold block
// Assumes: nothing
// Notes: link states are Gray coded along deselect, opcode, body
package fsp_pkg;
   typedef enum logic [1:0] {
      FSP_DESEL = 2'h0,
      FSP_OPCODE = 2'h1,
      FSP_BODY = 2'h3
   } fsp_link_t;

   typedef enum logic [1:0] {
      FSP_OP_NONE = 2'h0,
      FSP_OP_PROG = 2'h1,
      FSP_OP_SECT = 2'h2,
      FSP_OP_BULK = 2'h3
   } fsp_op_t;

   typedef struct packed {
      fsp_link_t link;
      logic hold;
      logic [11:0] bitCnt;
      logic [7:0] shiftIn;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] srData;
      logic [7:0] outShift;
      logic soBit;
      logic soOe;
      logic lock;
      logic [3:0] guard;
      logic latch;
      logic srBusy;
      logic [15:0] srTimer;
      logic arrWait;
      logic arrSeen;
      logic opStart;
      fsp_op_t opKind;
      logic [23:0] opAddr;
      logic dataValid;
      logic [7:0] dataByte;
      logic sckPrev;
      logic holdPrev;
   } fsp_state_t;
endpackage

//--- core/fsp_sync.sv
// Purpose: two-stage synchroniser for the serial pins
// Assumes: pins are asynchronous to clk_sys
// Notes: the first stage feeds only the second
`timescale 1ns/10ps
`include "fsp_map.svh"
module fsp_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pins in, stable copy out
   input wire logic [`FSP_PIN_W-1:0] pinAsync,
   output logic [`FSP_PIN_W-1:0] pinSync
);
   typedef struct packed {
      logic [`FSP_PIN_W-1:0] meta;
      logic [`FSP_PIN_W-1:0] stable;
   } fsp_sync_t;

   fsp_sync_t r;
   fsp_sync_t n;

   always_comb begin
      n.meta = pinAsync;
      n.stable = r.meta;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= {`FSP_PIN_IDLE, `FSP_PIN_IDLE};
      end else begin
         r <= n;
      end
   end

   assign pinSync = r.stable;
endmodule

//--- core/fsp_guard_decode.sv
// Purpose: software protect region decode for both sector variants
// Assumes: regions grow downward from the top of a 16 MB array
// Notes: combinational; sector erase targets are sector aligned
`timescale 1ns/10ps
`include "fsp_map.svh"
module fsp_guard_decode (
   // guard code and variant
   input wire logic [3:0] guardBits,
   input wire logic sector64k,
   // target address and verdict
   input wire logic [23:0] addr,
   output logic addrGuarded,
   output logic anyGuard
);
   // size of the top region in 128 KB units
   function automatic logic [7:0] fsp_units(input logic [3:0] g, input logic s64);
      logic [7:0] u;
      u = 8'h00;
      if (s64) begin
         if (g[3]) begin
            u = `FSP_UNITS_ALL;
         end else if (g[2:0] != 3'h0) begin
            u = 8'h01 << (g[2:0] - 3'h1);
         end
      end else begin
         if (g[2:0] == 3'h7) begin
            u = `FSP_UNITS_ALL;
         end else if (g[2:0] != 3'h0) begin
            u = 8'h02 << (g[2:0] - 3'h1);
         end
      end
      return u;
   endfunction

   logic [6:0] fromTop;

   always_comb begin
      fromTop = ~addr[`FSP_UNIT_HI:`FSP_UNIT_LO];
      addrGuarded = {1'b0, fromTop} < fsp_units(guardBits, sector64k);
      anyGuard = fsp_units(guardBits, sector64k) != 8'h00;
   end
endmodule

//--- core/fsp_flash_guard.sv
// Purpose: status, write latch, region guard and hold control of a serial flash
// Assumes: array engine raises arrayBusy the cycle after opStart and holds it to the end
// Notes: all pins pass fsp_sync; SCK edges are found by sampling on clk_sys
`timescale 1ns/10ps
`include "fsp_map.svh"
module fsp_flash_guard #(
   parameter logic [15:0] SR_WRITE_CYCLES = `FSP_SR_WRITE_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // serial pins
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic holdN,
   input wire logic wpN,
   output logic so,
   output logic soOe,
   // variant strap, high for 64 KB sectors
   input wire logic sector64k,
   // array engine
   input wire logic arrayBusy,
   output logic opStart,
   output fsp_pkg::fsp_op_t opKind,
   output logic [23:0] opAddr,
   output logic dataValid,
   output logic [7:0] dataByte,
   // status view
   output logic [7:0] statusByte
);
   fsp_pkg::fsp_state_t r;
   fsp_pkg::fsp_state_t n;
   logic [`FSP_PIN_W-1:0] pinS;
   logic sckS, csNS, siS, holdNS, wpNS;
   logic sckRise, sckFall, holdEdge, hwGuard, busy, whole, guardHit, anyGuard;
   logic [7:0] inByte;
   logic [3:0] newGuard;

   // shared acceptance test of the modifying commands
   function automatic logic fsp_write_ok(input logic latchOn, input logic byteWhole, input logic [11:0] cnt,
         input logic [11:0] minCnt);
      return latchOn && byteWhole && cnt >= minCnt;
   endfunction

   fsp_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinAsync({wpN, holdN, si, csN, sck}),
      .pinSync(pinS)
   );

   fsp_guard_decode u_guard (
      .guardBits(r.guard),
      .sector64k(sector64k),
      .addr(r.addr),
      .addrGuarded(guardHit),
      .anyGuard(anyGuard)
   );

   assign {wpNS, holdNS, siS, csNS, sckS} = pinS;

   always_comb begin
      sckRise = sckS && !r.sckPrev;
      sckFall = !sckS && r.sckPrev;
      holdEdge = holdNS != r.holdPrev;
      hwGuard = r.lock && !wpNS;
      busy = r.srBusy || r.arrWait || arrayBusy;
      whole = r.bitCnt[2:0] == `FSP_BYTE_WHOLE;
      inByte = {r.shiftIn[6:0], siS};
      newGuard = r.srData[`FSP_ST_GUARD_HI:`FSP_ST_GUARD_LO];
      if (!sector64k) begin
         newGuard[3] = 1'b0;
      end
      statusByte = 8'h00;
      statusByte[`FSP_ST_BUSY] = busy;
      statusByte[`FSP_ST_LATCH] = r.latch;
      statusByte[`FSP_ST_GUARD_HI:`FSP_ST_GUARD_LO] = r.guard;
      statusByte[`FSP_ST_LOCK] = r.lock;
   end

   always_comb begin
      n = r;
      n.opStart = 1'b0;
      n.dataValid = 1'b0;
      n.sckPrev = sckS;
      n.holdPrev = holdNS;
      // running operations advance regardless of hold or select
      if (r.srBusy) begin
         if (r.srTimer == 16'h0000) begin
            n.srBusy = 1'b0;
            n.latch = 1'b0;
         end else begin
            n.srTimer = r.srTimer - 16'h0001;
         end
      end
      if (r.arrWait) begin
         if (arrayBusy) begin
            n.arrSeen = 1'b1;
         end else if (r.arrSeen) begin
            n.arrWait = 1'b0;
            n.arrSeen = 1'b0;
            n.latch = 1'b0;
         end
      end
      if (csNS) begin
         // command runs on deselect unless hold aborted it or the busy status bit is set
         if (r.link == fsp_pkg::FSP_BODY && !r.hold && !busy) begin
            case (r.opcode)
               `FSP_CMD_WR_ENABLE: begin
                  n.latch = 1'b1;
               end
               `FSP_CMD_WR_DISABLE: begin
                  n.latch = 1'b0;
               end
               `FSP_CMD_STAT_WRITE: begin
                  if (fsp_write_ok(r.latch, whole, r.bitCnt, `FSP_CNT_SRDATA) && !hwGuard) begin
                     n.lock = r.srData[`FSP_ST_LOCK];
                     n.guard = newGuard;
                     n.srBusy = 1'b1;
                     n.srTimer = SR_WRITE_CYCLES;
                  end
               end
               `FSP_CMD_PAGE_PROG: begin
                  if (fsp_write_ok(r.latch, whole, r.bitCnt, `FSP_CNT_PROG) && !guardHit) begin
                     n.opStart = 1'b1;
                     n.opKind = fsp_pkg::FSP_OP_PROG;
                     n.opAddr = r.addr;
                     n.arrWait = 1'b1;
                  end
               end
               `FSP_CMD_SECT_ERASE: begin
                  if (fsp_write_ok(r.latch, whole, r.bitCnt, `FSP_CNT_ADDR) && !guardHit) begin
                     n.opStart = 1'b1;
                     n.opKind = fsp_pkg::FSP_OP_SECT;
                     n.opAddr = r.addr;
                     n.arrWait = 1'b1;
                  end
               end
               `FSP_CMD_BULK_ERASE: begin
                  if (fsp_write_ok(r.latch, whole, r.bitCnt, `FSP_CNT_OPCODE) && !anyGuard) begin
                     n.opStart = 1'b1;
                     n.opKind = fsp_pkg::FSP_OP_BULK;
                     n.opAddr = r.addr;
                     n.arrWait = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
         n.link = fsp_pkg::FSP_DESEL;
         n.hold = 1'b0;
         n.bitCnt = 12'h000;
      end else begin
         if (r.link == fsp_pkg::FSP_DESEL) begin
            n.link = fsp_pkg::FSP_OPCODE;
         end
         if ((holdEdge && !sckS) || sckFall) begin
            n.hold = !holdNS;
         end
         if (sckRise && !r.hold) begin
            n.shiftIn = inByte;
            n.bitCnt = r.bitCnt + 12'h001;
            if (r.bitCnt[2:0] == `FSP_BYTE_LAST) begin
               if (r.link == fsp_pkg::FSP_OPCODE) begin
                  n.opcode = inByte;
                  n.link = fsp_pkg::FSP_BODY;
                  if (inByte == `FSP_CMD_STAT_READ) begin
                     n.outShift = statusByte;
                  end
               end else if (r.opcode == `FSP_CMD_STAT_READ) begin
                  n.outShift = statusByte;
               end else if (r.opcode == `FSP_CMD_STAT_WRITE) begin
                  if (n.bitCnt == `FSP_CNT_SRDATA) begin
                     n.srData = inByte;
                  end
               end else if (r.opcode == `FSP_CMD_PAGE_PROG || r.opcode == `FSP_CMD_SECT_ERASE) begin
                  if (n.bitCnt <= `FSP_CNT_ADDR) begin
                     n.addr = {r.addr[15:0], inByte};
                  end else if (r.opcode == `FSP_CMD_PAGE_PROG) begin
                     n.dataValid = 1'b1;
                     n.dataByte = inByte;
                  end
               end
            end
         end
         // status bits leave on SCK falls
         if (sckFall && !r.hold && !n.hold && r.link == fsp_pkg::FSP_BODY
               && r.opcode == `FSP_CMD_STAT_READ) begin
            n.soBit = r.outShift[7];
            n.outShift = {r.outShift[6:0], 1'b0};
         end
      end
      n.soOe = !csNS && !n.hold && n.link == fsp_pkg::FSP_BODY
         && n.opcode == `FSP_CMD_STAT_READ;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         // pause pin idles high, so no false pause edge follows reset
         r.holdPrev <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign so = r.soBit;
   assign soOe = r.soOe;
   assign opStart = r.opStart;
   assign opKind = r.opKind;
   assign opAddr = r.opAddr;
   assign dataValid = r.dataValid;
   assign dataByte = r.dataByte;

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   logic execCycle;
   assign execCycle = csNS && r.link == fsp_pkg::FSP_BODY && !r.hold && !busy;

   a_busy_shown: assert property (r.srBusy || r.arrWait |-> statusByte[`FSP_ST_BUSY])
      else $error("busy bit low during operation");
   a_latch_arm: assert property (execCycle && r.opcode == `FSP_CMD_WR_ENABLE |=> r.latch)
      else $error("write enable did not set latch");
   a_latch_drop: assert property (r.srBusy && r.srTimer == 16'h0000 |=> !r.latch && !r.srBusy)
      else $error("latch kept after status write");
   a_lock_frozen: assert property (hwGuard |=> $stable(r.lock) && $stable(r.guard))
      else $error("locked status bits changed");
   a_count_whole: assert property (execCycle && !whole |=> !r.opStart && !$rose(r.srBusy))
      else $error("partial byte command executed");
   a_guard_block: assert property (execCycle && guardHit && r.opcode != `FSP_CMD_BULK_ERASE
      |=> !r.opStart)
      else $error("guarded address launched");
   a_no_latch_idle: assert property (execCycle && !r.latch |=> !r.opStart && !r.srBusy)
      else $error("command ran without latch");
   a_hold_enter: assert property (!csNS && $fell(holdNS) && !sckS && !r.hold
      |=> r.hold)
      else $error("hold not entered");
   a_hold_quiet: assert property (r.hold && !csNS |-> !r.soOe ##1 $stable(r.bitCnt) || csNS)
      else $error("activity during hold");
   a_hold_runs: assert property (r.srBusy && r.srTimer != 16'h0000 && r.hold
      |=> r.srTimer == $past(r.srTimer) - 16'h0001)
      else $error("hold stalled status write");
   a_desel_reset: assert property (csNS |=> r.link == fsp_pkg::FSP_DESEL && !r.hold
      && r.bitCnt == 12'h000)
      else $error("interface not reset on deselect");

   // latch bookkeeping, guard refusals and link timing
   a_write_disable_cmd_clear: assert property (execCycle && r.opcode == `FSP_CMD_WR_DISABLE
      |=> !r.latch)
      else $error("write disable left latch set");
   a_arr_done: assert property (r.arrWait && r.arrSeen && !arrayBusy
      |=> !r.latch && !r.arrWait)
      else $error("latch kept after array operation");
   a_bulk_guard: assert property (execCycle && anyGuard && r.opcode == `FSP_CMD_BULK_ERASE
      |=> !r.opStart)
      else $error("bulk erase launched under guard");
   a_hw_refuse: assert property (execCycle && hwGuard && r.opcode == `FSP_CMD_STAT_WRITE
      |=> !r.srBusy)
      else $error("status write ran under hardware guard");
   a_hold_late: assert property (!csNS && sckFall && !holdNS
      |=> r.hold)
      else $error("hold not entered at clock fall");
   a_hold_exit: assert property (!csNS && $rose(holdNS) && !sckS && r.hold
      |=> !r.hold)
      else $error("hold not left");
   a_so_steady: assert property (!sckFall
      |=> $stable(r.soBit))
      else $error("serial out moved without clock fall");
   a_cnt_rise: assert property (!csNS && !sckRise
      |=> $stable(r.bitCnt))
      else $error("bit counted without clock rise");
   a_wip_poll: assert property (!csNS && sckRise && !r.hold && r.link == fsp_pkg::FSP_BODY
      && r.opcode == `FSP_CMD_STAT_READ && r.bitCnt[2:0] == `FSP_BYTE_LAST |=> r.outShift == $past(statusByte))
      else $error("status byte not reloaded");
   a_oe_desel: assert property (csNS
      |=> !r.soOe)
      else $error("serial out driven while deselected");
endmodule

//--- dv/fsp_host_model.sv
// Purpose: serial bus master model driving the flash protect and hold block
// Assumes: frames run at 16 clk_sys per SCK period, modes 0 and 3
// Notes: SI is inverted between frames; a released SO reads high as if pulled up
`timescale 1ns/10ps
module fsp_host_model (
   // clock
   input wire logic clk_sys,
   // serial pins
   output logic sck,
   output logic csN,
   output logic si,
   output logic holdN,
   input wire logic so,
   input wire logic soOe
);
   logic idleHigh;
   logic oeInHold;

   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si = 1'b0;
      holdN = 1'b1;
      idleHigh = 1'b0;
      oeInHold = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // pause with SCK low, clock junk meanwhile, optionally deselect inside
   task automatic pause(input logic abort);
      wt(4);
      holdN = 1'b0;
      repeat (2) begin
         wt(8);
         sck = 1'b1;
         si = ~si;
         wt(8);
         oeInHold = oeInHold | soOe;
         sck = 1'b0;
      end
      if (abort) csN = 1'b1;
      wt(8);
      holdN = 1'b1;
      wt(8);
   endtask

   // msb first; data sampled on rise, SO read just before each rise
   task automatic frame(input int nBits, input logic [63:0] dat, input int holdAt, input logic abort,
         output logic [7:0] rx);
      sck = idleHigh;
      wt(8);
      csN = 1'b0;
      wt(8);
      for (int i = nBits - 1; i >= 0; i--) begin
         sck = 1'b0;
         if (nBits - 1 - i == holdAt) pause(abort);
         if (csN) break;
         si = dat[i];
         wt(8);
         rx = {rx[6:0], soOe ? so : 1'b1};
         sck = 1'b1;
         wt(8);
      end
      sck = idleHigh;
      if (holdAt == nBits) pause(abort);
      wt(8);
      csN = 1'b1;
      si = ~si;
      wt(8);
   endtask
endmodule

//--- dv/testbench.sv
// Purpose: self-checking bench of the flash protect and hold block
// Assumes: host model drives sck, csN, si and holdN, bench drives wpN and plays the array engine
// Notes: status write time shortened to 64 cycles so a hold can overlap it
`timescale 1ns/10ps
`include "fsp_map.svh"
module testbench;
   logic clk_sys, rst_n, sck, csN, si, holdN, wpN, so, soOe, sector64k, arrayBusy, opStart, dataValid;
   fsp_pkg::fsp_op_t opKind, lastKind;
   logic [7:0] dataByte, statusByte, rx, lastData;
   logic [23:0] opAddr, lastAddr, base;
   int errors, n_tests, nStart, engCnt;

   fsp_flash_guard #(.SR_WRITE_CYCLES(16'h0040)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .csN(csN),
      .si(si), .holdN(holdN), .wpN(wpN), .so(so), .soOe(soOe), .sector64k(sector64k), .arrayBusy(arrayBusy),
      .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .dataValid(dataValid), .dataByte(dataByte),
      .statusByte(statusByte));
   fsp_host_model host (.clk_sys(clk_sys), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so), .soOe(soOe));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   // array engine: busy from the cycle after a launch for 20 cycles
   always @(posedge clk_sys) begin
      if (opStart) begin
         nStart <= nStart + 1;
         lastAddr <= opAddr;
         lastKind <= opKind;
         engCnt <= 20;
      end else if (engCnt != 0) engCnt <= engCnt - 1;
      if (dataValid) lastData <= dataByte;
      arrayBusy <= opStart || engCnt > 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic restart(input logic v);
      rst_n = 1'b0;
      sector64k = v;
      host.wt(3);
      rst_n = 1'b1;
      host.wt(4);
   endtask

   task automatic cmd(input logic [7:0] op);
      host.frame(8, {56'h0, op}, -1, 1'b0, rx);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 200 && statusByte[0] !== 1'b0; i++) host.wt(1);
      check(statusByte[0], 1'b0);
   endtask

   task automatic status_write_cmd(input logic [7:0] v);
      cmd(`FSP_CMD_WR_ENABLE);
      host.frame(16, {48'h0, 8'h01, v}, -1, 1'b0, rx);
      wait_idle();
   endtask

   // modifying array command; ok says whether it must launch
   task automatic arr(input logic [7:0] opc, input int nb, input logic [23:0] addr, input logic ok,
         input fsp_pkg::fsp_op_t kind);
      int n0;
      n0 = nStart;
      cmd(`FSP_CMD_WR_ENABLE);
      host.frame(nb, {24'h0, opc, addr, 8'ha5} >> (40 - nb), -1, 1'b0, rx);
      host.wt(4);
      check(nStart - n0, ok);
      check(statusByte[0], ok);
      if (ok) check(lastKind, kind);
      if (ok && nb > 8) check(lastAddr, addr);
      wait_idle();
      check(statusByte[1], !ok);
      cmd(`FSP_CMD_WR_DISABLE);
   endtask

   initial begin
      errors = 0;
      n_tests = 0;
      nStart = 0;
      engCnt = 0;
      arrayBusy = 1'b0;
      wpN = 1'b1;
      restart(1'b0);
      check(statusByte, 8'h00);
      host.frame(8, 64'h06, 8, 1'b1, rx);
      check(statusByte, 8'h00);
      cmd(`FSP_CMD_WR_ENABLE);
      check(statusByte, 8'h02);
      host.frame(16, 64'h0500, -1, 1'b0, rx);
      check(rx, 8'h02);
      host.frame(16, 64'h0100, -1, 1'b0, rx);
      host.frame(8, 64'h05, 0, 1'b0, rx);
      check(statusByte, 8'h00);
      cmd(`FSP_CMD_WR_ENABLE);
      host.idleHigh = 1'b1;
      host.frame(16, 64'h0500, 12, 1'b0, rx);
      check(rx, 8'h02);
      check(host.oeInHold, 1'b0);
      host.idleHigh = 1'b0;
      cmd(`FSP_CMD_WR_DISABLE);
      check(statusByte, 8'h00);
      $display("latch and hold test done");
      host.frame(40, 64'h02_0001_00a5, -1, 1'b0, rx);
      host.wt(4);
      check(nStart, 0);
      arr(`FSP_CMD_PAGE_PROG, 40, 24'h00_1234, 1'b1, fsp_pkg::FSP_OP_PROG);
      check(lastData, 8'ha5);
      arr(`FSP_CMD_SECT_ERASE, 32, 24'h10_0000, 1'b1, fsp_pkg::FSP_OP_SECT);
      arr(`FSP_CMD_BULK_ERASE, 8, 24'h00_0000, 1'b1, fsp_pkg::FSP_OP_BULK);
      cmd(`FSP_CMD_WR_ENABLE);
      host.frame(17, 64'h0_0238, -1, 1'b0, rx);
      host.wt(12);
      check(statusByte, 8'h02);
      cmd(`FSP_CMD_WR_DISABLE);
      $display("command test done");
      for (int v = 0; v < 2; v++) begin
         restart(v[0]);
         for (int k = 1; k <= 7 + v; k++) begin
            status_write_cmd({2'b00, k[3:0], 2'b00});
            check(statusByte, {2'b00, k[3:0], 2'b00});
            if (k == 7 + v) arr(`FSP_CMD_PAGE_PROG, 40, 24'h00_0000, 1'b0, fsp_pkg::FSP_OP_PROG);
            else begin
               base = 24'h00_0000 - (24'h00_0001 << (17 - v + k));
               arr(`FSP_CMD_SECT_ERASE, 32, base, 1'b0, fsp_pkg::FSP_OP_SECT);
               arr(`FSP_CMD_PAGE_PROG, 40, base - 24'h00_0001, 1'b1, fsp_pkg::FSP_OP_PROG);
            end
         end
         arr(`FSP_CMD_BULK_ERASE, 8, 24'h00_0000, 1'b0, fsp_pkg::FSP_OP_BULK);
      end
      $display("region test done");
      restart(1'b0);
      status_write_cmd(8'hbc);
      check(statusByte, 8'h9c);
      wpN = 1'b0;
      cmd(`FSP_CMD_WR_ENABLE);
      host.frame(16, 64'h0100, -1, 1'b0, rx);
      host.wt(12);
      check(statusByte, 8'h9e);
      wpN = 1'b1;
      cmd(`FSP_CMD_WR_DISABLE);
      status_write_cmd(8'h00);
      check(statusByte, 8'h00);
      wpN = 1'b0;
      status_write_cmd(8'h04);
      check(statusByte, 8'h04);
      $display("hardware guard test done");
      end_sim();
   end

   initial begin
      #800000;
      errors++;
      end_sim();
   end
endmodule
